/* sdcr_defines.svh */
// Field positions, codes and counts for the synthesizer control registers
// Contract
// - Word with select bits 00 loads the feedback divider register.
// - Word with select bits 01 loads the reference divider register.
// - Word with select bits 10 loads the control register.
// - Word with select bits 11 loads the noise and spur register.
// - Feedback word holds nine-bit integer and twelve-bit numerator fields.
// - Quick-settle bit set forces maximum pump current, else control value.
// - Quick-settle monitor mode grounds output when bit set, else floats.
// - Load control bit set makes the modulus field the resync delay.
// - Three-bit monitor select in bits 22..20 picks the monitor source.
// - Precision bit 0 needs 24 good compare cycles for lock.
// - Precision bit 1 needs 40 good compare cycles for lock.
// - Lock holds until a new channel word, power-down or one large error.
// - Reference word carries a twelve-bit fraction modulus field.
// - New modulus is latched, then applied at the next feedback write.
// - Control bit 2 set holds all synthesizer counters in reset.
// - Control bit 3 set floats the charge pump output.
// - Control bit 4 enters power-down, clear resumes; registers kept.
// - Power-down loads counters, floats pump and resets lock detect.
// - Serial input register keeps loading words during power-down.
`ifndef SDCR_DEFINES_SVH
`define SDCR_DEFINES_SVH

`define SDCR_WORD_W      24
`define SDCR_SEL_MSB     1
`define SDCR_FB_QS       23
`define SDCR_FB_INT_MSB  22
`define SDCR_FB_INT_LSB  14
`define SDCR_FB_NUM_MSB  13
`define SDCR_FB_NUM_LSB  2
`define SDCR_RF_LOAD     23
`define SDCR_RF_MON_MSB  22
`define SDCR_RF_MON_LSB  20
`define SDCR_RF_PRE      18
`define SDCR_RF_DIV_MSB  17
`define SDCR_RF_DIV_LSB  14
`define SDCR_RF_MDL_MSB  13
`define SDCR_RF_MDL_LSB  2
`define SDCR_CT_RSY_MSB  15
`define SDCR_CT_RSY_LSB  12
`define SDCR_CT_DBL      11
`define SDCR_CT_CP_MSB   10
`define SDCR_CT_CP_LSB   7
`define SDCR_CT_POL      6
`define SDCR_CT_PREC     5
`define SDCR_CT_PD       4
`define SDCR_CT_TRI      3
`define SDCR_CT_CRST     2
`define SDCR_NS_MSB      10
`define SDCR_NS_LSB      2
`define SDCR_CP_MAX      4'hF
`define SDCR_CTRL_RST    16'h0000
`define SDCR_WORD_RST    24'h000000
`define SDCR_LOCK_LO     6'h18
`define SDCR_LOCK_HI     6'h28

`endif

/* sdcr_pkg.sv */
// Shared types and decode helpers for the synthesizer control block
package sdcr_pkg;
  `include "sdcr_defines.svh"

  typedef logic [`SDCR_WORD_W-1:0] sdcr_word_t;

  typedef enum logic [1:0] {
    SDCR_FB   = 2'h0,
    SDCR_REF  = 2'h1,
    SDCR_CTRL = 2'h2,
    SDCR_NS   = 2'h3
  } sdcr_addr_t;

  typedef enum logic [2:0] {
    SDCR_MON_OFF  = 3'h0,
    SDCR_MON_DLD  = 3'h1,
    SDCR_MON_NDIV = 3'h2,
    SDCR_MON_HIGH = 3'h3,
    SDCR_MON_RDIV = 3'h4,
    SDCR_MON_ALD  = 3'h5,
    SDCR_MON_QS   = 3'h6,
    SDCR_MON_LOW  = 3'h7
  } sdcr_mon_t;

  function automatic logic sdcr_hit(sdcr_word_t w, sdcr_addr_t a);
    sdcr_hit = (w[`SDCR_SEL_MSB:0] == a);
  endfunction : sdcr_hit
endpackage : sdcr_pkg

/* sdcr_word_if.sv */
// Received word and its strobe, from serial receiver to register core
`timescale 1ns/100ps
interface sdcr_word_if;
  import sdcr_pkg::*;
  sdcr_word_t wordData;
  logic       wordStb;
  modport rx   (output wordData, output wordStb);
  modport core (input  wordData, input  wordStb);
endinterface : sdcr_word_if

/* sdcr_serial_rx.sv */
// Three-wire serial receiver with latch-enable crossing into sys_clk
`timescale 1ns/100ps
module sdcr_serial_rx
  import sdcr_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst_b,
  input  wire logic  serClk,
  input  wire logic  serData,
  input  wire logic  latchEn,
  sdcr_word_if.rx    word
);
  sdcr_word_t shiftReg;
  logic [1:0] leSync;
  logic       leDly;
  sdcr_word_t wordData;
  logic       wordStb;
  wire        leRise = leSync[1] & ~leDly;

  // No reset here: the link clock may be idle while sys reset is held
  always_ff @(posedge serClk) begin
    shiftReg <= {shiftReg[`SDCR_WORD_W-2:0], serData};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      leSync <= 2'h0;
      leDly  <= 1'b0;
    end else begin
      leSync <= {leSync[0], latchEn};
      leDly  <= leSync[1];
    end
  end

  // Word is static while latch enable is high, so a plain capture is safe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wordData <= `SDCR_WORD_RST;
      wordStb  <= 1'b0;
    end else begin
      wordStb <= leRise;
      if (leRise) begin
        wordData <= shiftReg;
      end
    end
  end

  assign word.wordData = wordData;
  assign word.wordStb  = wordStb;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_latch_capture: assert property (leRise |=> wordStb ##1 !wordStb)
    else $error("latch enable did not give a single word strobe");
endmodule : sdcr_serial_rx

/* sdcr_lock_detect.sv */
// Digital lock detector counting good phase-compare cycles
`timescale 1ns/100ps
module sdcr_lock_detect
  import sdcr_pkg::*;
#(
  parameter int CNT_W = 6
)(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic compareTick,
  input  wire logic errBelowLock,
  input  wire logic errAboveLoss,
  input  wire logic precision,
  input  wire logic clear,
  output logic      lockDetect
);
  logic [2:0]       syncA;
  logic [2:0]       syncB;
  logic             tickDly;
  logic [CNT_W-1:0] goodCnt;
  wire              tickEdge = syncB[0] & ~tickDly;
  wire              isSmall  = syncB[1];
  wire              isLarge  = syncB[2];
  wire [CNT_W-1:0]  target   = precision ? CNT_W'(`SDCR_LOCK_HI)
                                         : CNT_W'(`SDCR_LOCK_LO);
  wire [CNT_W-1:0]  cntInc   = goodCnt + CNT_W'(1);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      syncA   <= 3'h0;
      syncB   <= 3'h0;
      tickDly <= 1'b0;
    end else begin
      syncA   <= {errAboveLoss, errBelowLock, compareTick};
      syncB   <= syncA;
      tickDly <= syncB[0];
    end
  end

  // Clear wins so a new channel or power-down always restarts the search
  always_ff @(posedge sys_clk) begin
    if (!rst_b || clear) begin
      goodCnt    <= '0;
      lockDetect <= 1'b0;
    end else if (tickEdge) begin
      if (isLarge) begin
        goodCnt    <= '0;
        lockDetect <= 1'b0;
      end else if (isSmall) begin
        goodCnt <= (cntInc >= target) ? goodCnt : cntInc;
        if (cntInc >= target) begin
          lockDetect <= 1'b1;
        end
      end else begin
        goodCnt <= '0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_lock_short: assert property ($rose(lockDetect) && !$past(precision)
    |-> $past(goodCnt) == CNT_W'(`SDCR_LOCK_LO - 1))
    else $error("lock set without 24 good cycles");
  a_lock_long: assert property ($rose(lockDetect) && $past(precision)
    |-> $past(goodCnt) == CNT_W'(`SDCR_LOCK_HI - 1))
    else $error("lock set without 40 good cycles");
  a_lock_hold: assert property ($fell(lockDetect)
    |-> $past(clear) || $past(tickEdge && isLarge))
    else $error("lock dropped without cause");
  a_lock_clear: assert property (clear |=> !lockDetect)
    else $error("lock kept after channel change or power-down");
endmodule : sdcr_lock_detect

/* sdcr_top.sv */
// Register core of the fractional-N synthesizer programming interface
`timescale 1ns/100ps
module sdcr_top
  import sdcr_pkg::*;
#(
  parameter int CP_W   = 4,
  parameter int CNT_W  = 6,
  parameter int SYNC_N = 3
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        serClk,
  input  wire logic        serData,
  input  wire logic        latchEn,
  input  wire logic        compareTick,
  input  wire logic        errBelowLock,
  input  wire logic        errAboveLoss,
  input  wire logic        fbDivOut,
  input  wire logic        refDivOut,
  input  wire logic        analogLock,
  output logic [8:0]       intValue,
  output logic [11:0]      numerator,
  output logic [11:0]      modulusActive,
  output logic [11:0]      modulusPending,
  output logic [11:0]      resyncDelay,
  output logic [3:0]       refDivide,
  output logic             prescalerSel,
  output logic [CP_W-1:0]  cpCurrent,
  output logic             cpPolarity,
  output logic             refDoubler,
  output logic [3:0]       resyncMode,
  output logic             cpThreeState,
  output logic             counterReset,
  output logic             counterLoad,
  output logic             powerDown,
  output logic [8:0]       noiseMode,
  output logic             lockDetect,
  output logic             monOut,
  output logic             monOutEn
);
  sdcr_word_if wordBus ();

  sdcr_word_t        fbWord;
  sdcr_word_t        refWord;
  logic [15:0]       ctrlWord;
  logic [8:0]        nsWord;
  logic [SYNC_N-1:0] pinS1;
  logic [SYNC_N-1:0] pinS2;
  logic              newChannel;
  logic              next_monOut;
  logic              next_monOutEn;

  sdcr_serial_rx u_rx (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .serClk  (serClk),
    .serData (serData),
    .latchEn (latchEn),
    .word    (wordBus.rx)
  );

  // Address decode of the latched word
  wire        wordStb  = wordBus.wordStb;
  sdcr_word_t wordData;
  assign wordData = wordBus.wordData;
  wire fbWrite   = wordStb & sdcr_hit(wordData, SDCR_FB);
  wire refWrite  = wordStb & sdcr_hit(wordData, SDCR_REF);
  wire ctrlWrite = wordStb & sdcr_hit(wordData, SDCR_CTRL);
  wire nsWrite   = wordStb & sdcr_hit(wordData, SDCR_NS);
  wire loadResync = wordData[`SDCR_RF_LOAD];

  // Field selection
  wire        quickSettle = fbWord[`SDCR_FB_QS];
  wire        pdBit   = ctrlWord[`SDCR_CT_PD];
  wire        triBit  = ctrlWord[`SDCR_CT_TRI];
  wire        crstBit = ctrlWord[`SDCR_CT_CRST];
  wire        precBit = ctrlWord[`SDCR_CT_PREC];
  wire [CP_W-1:0] cpProg = CP_W'(ctrlWord[`SDCR_CT_CP_MSB:`SDCR_CT_CP_LSB]);
  wire [2:0]  monSelRaw = refWord[`SDCR_RF_MON_MSB:`SDCR_RF_MON_LSB];
  sdcr_mon_t  monSel;
  assign monSel = sdcr_mon_t'(monSelRaw);
  wire        dldSync  = lockDetect;
  wire        fbSync   = pinS2[0];
  wire        refSync  = pinS2[1];
  wire        aldSync  = pinS2[2];

  // Async pins from the analog side pass two flops before use
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pinS1 <= '0;
      pinS2 <= '0;
    end else begin
      pinS1 <= SYNC_N'({analogLock, refDivOut, fbDivOut});
      pinS2 <= pinS1;
    end
  end

  // Register writes; nothing here depends upon power-down
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fbWord <= `SDCR_WORD_RST;
    end else if (fbWrite) begin
      fbWord <= wordData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      refWord <= `SDCR_WORD_RST;
    end else if (refWrite) begin
      refWord <= wordData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrlWord <= `SDCR_CTRL_RST;
      nsWord   <= '0;
    end else begin
      if (ctrlWrite) begin
        ctrlWord <= wordData[15:0];
      end
      if (nsWrite) begin
        nsWord <= wordData[`SDCR_NS_MSB:`SDCR_NS_LSB];
      end
    end
  end

  // Modulus double buffer: pending until the next feedback word
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      modulusPending <= '0;
      modulusActive  <= '0;
      resyncDelay    <= '0;
    end else begin
      if (refWrite && !loadResync) begin
        modulusPending <=
          wordData[`SDCR_RF_MDL_MSB:`SDCR_RF_MDL_LSB];
      end
      if (refWrite && loadResync) begin
        resyncDelay <= wordData[`SDCR_RF_MDL_MSB:`SDCR_RF_MDL_LSB];
      end
      if (fbWrite) begin
        modulusActive <= modulusPending;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      newChannel <= 1'b0;
    end else begin
      newChannel <= fbWrite;
    end
  end

  sdcr_lock_detect #(.CNT_W(CNT_W)) u_lock (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .compareTick  (compareTick),
    .errBelowLock (errBelowLock),
    .errAboveLoss (errAboveLoss),
    .precision    (precBit),
    .clear        (newChannel | pdBit),
    .lockDetect   (lockDetect)
  );

  // Outputs straight from stored fields
  assign intValue     = fbWord[`SDCR_FB_INT_MSB:`SDCR_FB_INT_LSB];
  assign numerator    = fbWord[`SDCR_FB_NUM_MSB:`SDCR_FB_NUM_LSB];
  assign refDivide    = refWord[`SDCR_RF_DIV_MSB:`SDCR_RF_DIV_LSB];
  assign prescalerSel = refWord[`SDCR_RF_PRE];
  assign cpPolarity   = ctrlWord[`SDCR_CT_POL];
  assign refDoubler   = ctrlWord[`SDCR_CT_DBL];
  assign resyncMode   = ctrlWord[`SDCR_CT_RSY_MSB:`SDCR_CT_RSY_LSB];
  assign noiseMode    = nsWord;
  assign powerDown    = pdBit;

  // Current override is combinational from stored bits only
  assign cpCurrent    = quickSettle ? CP_W'(`SDCR_CP_MAX) : cpProg;
  assign cpThreeState = triBit | pdBit;
  assign counterReset = crstBit;
  assign counterLoad  = pdBit;

  // Monitor source select; enable high while driving
  always_comb begin
    next_monOut   = 1'b0;
    next_monOutEn = 1'b1;
    case (monSel)
      SDCR_MON_OFF:  next_monOutEn = 1'b0;
      SDCR_MON_DLD:  next_monOut   = dldSync;
      SDCR_MON_NDIV: next_monOut   = fbSync;
      SDCR_MON_HIGH: next_monOut   = 1'b1;
      SDCR_MON_RDIV: next_monOut   = refSync;
      SDCR_MON_ALD:  next_monOut   = aldSync;
      SDCR_MON_QS:   next_monOutEn = quickSettle;
      SDCR_MON_LOW:  next_monOut   = 1'b0;
      default:       next_monOutEn = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      monOut   <= 1'b0;
      monOutEn <= 1'b0;
    end else begin
      monOut   <= next_monOut;
      monOutEn <= next_monOutEn;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_mod_latch;
    refWrite && !loadResync;
  endsequence

  sequence s_fb_apply;
    fbWrite ##1 1'b1;
  endsequence

  a_fb_store: assert property (fbWrite |=>
    intValue == $past(wordData[`SDCR_FB_INT_MSB:`SDCR_FB_INT_LSB])
    && numerator == $past(wordData[`SDCR_FB_NUM_MSB:`SDCR_FB_NUM_LSB]))
    else $error("feedback word not stored");

  a_ref_store: assert property (s_mod_latch |=>
    modulusPending == $past(wordData[`SDCR_RF_MDL_MSB:`SDCR_RF_MDL_LSB])
    && refDivide == $past(wordData[`SDCR_RF_DIV_MSB:`SDCR_RF_DIV_LSB]))
    else $error("reference word not stored");

  a_ctrl_store: assert property (ctrlWrite |=>
    counterReset == $past(wordData[`SDCR_CT_CRST])
    && powerDown == $past(wordData[`SDCR_CT_PD]))
    else $error("control word not stored");

  a_ns_store: assert property (nsWrite |=>
    noiseMode == $past(wordData[`SDCR_NS_MSB:`SDCR_NS_LSB]))
    else $error("noise word not stored");

  a_mod_buffer: assert property (s_mod_latch ##1 !fbWrite
    |=> $stable(modulusActive))
    else $error("modulus applied before feedback write");

  a_mod_apply: assert property (s_fb_apply
    |-> modulusActive == $past(modulusPending))
    else $error("modulus not applied by feedback write");

  a_resync_load: assert property (refWrite && loadResync
    |=> $stable(modulusPending) && resyncDelay ==
        $past(wordData[`SDCR_RF_MDL_MSB:`SDCR_RF_MDL_LSB]))
    else $error("resync delay handling wrong");

  a_qs_current: assert property (quickSettle
    |-> cpCurrent == CP_W'(`SDCR_CP_MAX))
    else $error("quick-settle did not force maximum current");

  a_mon_settle: assert property ($past(monSel) == SDCR_MON_QS
    |-> monOutEn == $past(quickSettle) && !monOut)
    else $error("quick-settle monitor level wrong");

  a_mon_low: assert property ($past(monSel) == SDCR_MON_LOW
    |-> monOutEn && !monOut)
    else $error("monitor code 111 not low");

  a_pd_force: assert property (pdBit
    |-> cpThreeState && counterLoad ##1 !lockDetect [*2])
    else $error("power-down did not force idle state");

  a_cnt_reset: assert property (crstBit |-> counterReset)
    else $error("counter reset not held");

  a_cp_float: assert property (triBit |-> cpThreeState)
    else $error("charge pump not floated");

  a_pd_retain: assert property (pdBit && !fbWrite
    |=> $stable(intValue))
    else $error("register lost during power-down");

  a_pd_load: assert property (pdBit && fbWrite |=>
    intValue == $past(wordData[`SDCR_FB_INT_MSB:`SDCR_FB_INT_LSB]))
    else $error("feedback word lost while powered down");

  a_new_chan: assert property (s_fb_apply |=> !lockDetect)
    else $error("lock kept after feedback write");

  a_cp_program: assert property (ctrlWrite && !quickSettle |=>
    cpCurrent == CP_W'($past(wordData[`SDCR_CT_CP_MSB:`SDCR_CT_CP_LSB])))
    else $error("programmed pump current not used");

  // Monitor follows its source one cycle late, as it is registered
  a_mon_off: assert property ($past(monSel) == SDCR_MON_OFF
    |-> !monOutEn)
    else $error("monitor driven while three-stated");

  a_mon_high: assert property ($past(monSel) == SDCR_MON_HIGH
    |-> monOutEn && monOut)
    else $error("monitor code 011 not high");

  a_mon_dld: assert property ($past(monSel) == SDCR_MON_DLD
    |-> monOutEn && monOut == $past(lockDetect))
    else $error("monitor does not show digital lock");
endmodule : sdcr_top

/* sdcr_host_model.sv */
// Host-side model driving the three-wire programming link
`timescale 1ns/100ps
module sdcr_host_model (
  output logic serClk,
  output logic serData,
  output logic latchEn
);
  initial begin
    serClk  = 1'b0;
    serData = 1'b0;
    latchEn = 1'b0;
  end

  // Link clock stands still low between frames
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      serData = w[i];
      #16 serClk = 1'b1;
      #16 serClk = 1'b0;
    end
    // Released line shows the inverse, so a stale bit is never trusted
    serData = ~w[0];
    #8 latchEn = 1'b1;
    #200 latchEn = 1'b0;
    #200;
  endtask : send
endmodule : sdcr_host_model

/* tb_synth_divider_control_regs.sv */
// Self-checking bench for the synthesizer control registers
`timescale 1ns/100ps
module tb_synth_divider_control_regs;
  import sdcr_pkg::*;
  typedef struct { string n; logic [23:0] v; } sdcr_note_t;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        compareTick = 1'b0;
  logic        errBelowLock = 1'b0;
  logic        errAboveLoss = 1'b0;
  logic        fbDivOut = 1'b0;
  logic        refDivOut = 1'b0;
  logic        analogLock = 1'b0;
  wire         serClk;
  wire         serData;
  wire         latchEn;
  logic [8:0]  intValue, noiseMode, mInt, mNs;
  logic [11:0] numerator, modulusActive, modulusPending, resyncDelay;
  logic [11:0] mNum, mAct, mPend, mRsy;
  logic [3:0]  refDivide, cpCurrent, resyncMode, mRdiv;
  logic        prescalerSel, cpPolarity, refDoubler, cpThreeState;
  logic        counterReset, counterLoad, powerDown, lockDetect;
  logic        monOut, monOutEn, mPre, mQs, mLock, mv;
  logic [15:0] mCtl;
  logic [2:0]  mSel;
  int          errors = 0;
  int          checkCount = 0;
  int          seed;
  sdcr_note_t  notes[$];
  event        chk;

  always #12.5 sys_clk = ~sys_clk;

  sdcr_host_model host (.serClk(serClk), .serData(serData),
    .latchEn(latchEn));

  sdcr_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .serClk(serClk),
    .serData(serData), .latchEn(latchEn), .compareTick(compareTick),
    .errBelowLock(errBelowLock), .errAboveLoss(errAboveLoss),
    .fbDivOut(fbDivOut), .refDivOut(refDivOut), .analogLock(analogLock),
    .intValue(intValue), .numerator(numerator),
    .modulusActive(modulusActive), .modulusPending(modulusPending),
    .resyncDelay(resyncDelay), .refDivide(refDivide),
    .prescalerSel(prescalerSel), .cpCurrent(cpCurrent),
    .cpPolarity(cpPolarity), .refDoubler(refDoubler),
    .resyncMode(resyncMode), .cpThreeState(cpThreeState),
    .counterReset(counterReset), .counterLoad(counterLoad),
    .powerDown(powerDown), .noiseMode(noiseMode),
    .lockDetect(lockDetect), .monOut(monOut), .monOutEn(monOutEn));

  task automatic note(input string s, input logic [23:0] v);
    notes.push_back('{s, v});
  endtask : note

  function automatic logic [23:0] obs(input string s);
    case (s)
      "intValue":  obs = {15'h0, intValue};
      "numerator": obs = {12'h0, numerator};
      "modAct":    obs = {12'h0, modulusActive};
      "modPend":   obs = {12'h0, modulusPending};
      "resync":    obs = {12'h0, resyncDelay};
      "refDivide": obs = {20'h0, refDivide};
      "prescaler": obs = {23'h0, prescalerSel};
      "cpCurrent": obs = {20'h0, cpCurrent};
      "cpPol":     obs = {23'h0, cpPolarity};
      "doubler":   obs = {23'h0, refDoubler};
      "rsyMode":   obs = {20'h0, resyncMode};
      "threeSt":   obs = {23'h0, cpThreeState};
      "cntReset":  obs = {23'h0, counterReset};
      "cntLoad":   obs = {23'h0, counterLoad};
      "powerDown": obs = {23'h0, powerDown};
      "noiseMode": obs = {15'h0, noiseMode};
      "lock":      obs = {23'h0, lockDetect};
      "monOut":    obs = {23'h0, monOut};
      default:     obs = {23'h0, monOutEn};
    endcase
  endfunction : obs

  task automatic check_all();
    note("intValue", mInt);
    note("numerator", mNum);
    note("modAct", mAct);
    note("modPend", mPend);
    note("resync", mRsy);
    note("refDivide", mRdiv);
    note("prescaler", mPre);
    note("cpCurrent", mQs ? 4'hF : mCtl[10:7]);
    note("cpPol", mCtl[6]);
    note("doubler", mCtl[11]);
    note("rsyMode", mCtl[15:12]);
    note("threeSt", mCtl[3] | mCtl[4]);
    note("cntReset", mCtl[2]);
    note("cntLoad", mCtl[4]);
    note("powerDown", mCtl[4]);
    note("noiseMode", mNs);
    note("lock", mLock);
    case (mSel)
      3'h1: mv = mLock;
      3'h2: mv = fbDivOut;
      3'h3: mv = 1'b1;
      3'h4: mv = refDivOut;
      3'h5: mv = analogLock;
      default: mv = 1'b0;
    endcase
    note("monOutEn", (mSel == 3'h6) ? mQs : (mSel != 3'h0));
    if (mSel != 3'h0) note("monOut", mv);
    -> chk;
    @(negedge sys_clk);
  endtask : check_all

  task automatic put(input logic [23:0] w);
    @(negedge sys_clk);
    host.send(w);
    case (w[1:0])
      2'h0: begin
        {mQs, mInt, mNum} = w[23:2];
        mAct = mPend;
        mLock = 1'b0;
      end
      2'h1: begin
        {mSel, mPre, mRdiv} = {w[22:20], w[18:14]};
        if (w[23]) mRsy = w[13:2];
        else mPend = w[13:2];
      end
      2'h2: begin
        mCtl = w[15:0];
        if (w[4]) mLock = 1'b0;
      end
      default: mNs = w[10:2];
    endcase
    check_all();
  endtask : put

  // Flags are {precision, power-down, pump three-state, counter reset}
  function automatic logic [23:0] cw(input logic [3:0] f);
    cw = {8'h00, 10'($urandom), f, 2'b10};
  endfunction : cw

  // Integer kept at 91 or more so either prescaler setting is legal
  function automatic logic [23:0] fw();
    fw = {1'($urandom), 9'(91 + $urandom_range(420)),
      12'($urandom_range(mPend)), 2'b00};
  endfunction : fw

  function automatic logic [23:0] rw(input logic ld, input logic [2:0] s);
    rw = {ld, s, 1'b0, 1'($urandom), 4'(1 + $urandom_range(14)),
      12'(1 + $urandom_range(4094)), 2'b01};
  endfunction : rw

  task automatic tick(input logic b, input logic a);
    @(negedge sys_clk);
    errBelowLock = b;
    errAboveLoss = a;
    repeat (2) @(negedge sys_clk);
    compareTick = 1'b1;
    repeat (4) @(negedge sys_clk);
    compareTick = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : tick

  task automatic end_sim();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  initial begin : watch
    sdcr_note_t n;
    forever begin
      @chk;
      while (notes.size() > 0) begin
        n = notes.pop_front();
        checkCount++;
        if (obs(n.n) !== n.v) begin
          errors++;
          $display("MISMATCH %s expected %0h seen %0h", n.n, n.v, obs(n.n));
        end
      end
    end
  end

  initial begin
    #400000;
    errors++;
    end_sim();
  end

  initial begin
    {mInt, mNum, mAct, mPend, mRsy, mRdiv, mPre, mQs} = '0;
    {mLock, mCtl, mNs, mSel} = '0;
    seed = $urandom(32'hB7EF09CF);
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_all();
    put(cw(4'b0011));
    put(rw(1'b0, 3'h1));
    put(fw() & 24'h7FFFFF);
    put(cw(4'b0000));
    put(24'h000003);
    put({13'h0, 9'($urandom) & 9'h0F1, 2'b11});
    for (int c = 0; c < 8; c++) begin
      @(negedge sys_clk);
      {fbDivOut, refDivOut, analogLock} = 3'($urandom);
      put(rw(1'b1, 3'(c)));
    end
    put(rw(1'b1, 3'h1));
    repeat (23) tick(1'b1, 1'b0);
    check_all();
    tick(1'b1, 1'b0);
    mLock = 1'b1;
    check_all();
    tick(1'b0, 1'b0);
    check_all();
    tick(1'b0, 1'b1);
    mLock = 1'b0;
    check_all();
    put(cw(4'b1000));
    repeat (39) tick(1'b1, 1'b0);
    check_all();
    tick(1'b1, 1'b0);
    mLock = 1'b1;
    check_all();
    put(fw());
    repeat (40) tick(1'b1, 1'b0);
    mLock = 1'b1;
    check_all();
    put(cw(4'b1100));
    put(rw(1'b0, 3'h6));
    put(fw() | 24'h800000);
    put(cw(4'b1000));
    end_sim();
  end
endmodule : tb_synth_divider_control_regs
